//--- pswo_pkg.sv
// pswo_pkg: constants and types for the pixel shift and window output block
package pswo_pkg;
  // ****************************************
  // array geometry and reset window
  // ****************************************
  localparam int SAMPLE_W = 10;
  localparam int COORD_W = 11;
  localparam logic [COORD_W-1:0] ARRAY_LINES = 11'h3ec;
  localparam logic [COORD_W-1:0] WIN_FIRST_RST = 11'h001;
  localparam logic [COORD_W-1:0] WIN_COUNT_RST = 11'h3ec;

  // ****************************************
  // shift modes
  // ****************************************
  typedef enum logic [1:0] {SHIFT_NONE, SHIFT_ONCE, SHIFT_TWICE} pswo_shift_type;
  localparam logic [SAMPLE_W-1:0] SAT_VALUE = 10'h3ff;
  localparam logic [SAMPLE_W-1:0] DARK_VALUE = 10'h000;

  // ****************************************
  // frame timing
  // ****************************************
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int LINE_WIN_TIME_NS = 20550;
  localparam int LINE_SKIP_TIME_NS = 7300;
  localparam int FRAME_OVH_TIME_NS = 204800;
  localparam int LINE_WIN_CYCLES = (LINE_WIN_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int LINE_SKIP_CYCLES = (LINE_SKIP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int FRAME_OVH_CYCLES = (FRAME_OVH_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PERIOD_W = 26;
  localparam logic [PERIOD_W-1:0] PERIOD_ZERO = 26'h0000000;
endpackage : pswo_pkg

//--- pswo_core.sv
// pswo_core: digital shift, output window gating and frame period check
`timescale 1ns/10ps
module pswo_core import pswo_pkg::*; #(
  parameter int unsigned LINE_WIN_CYC = LINE_WIN_CYCLES,
  parameter int unsigned LINE_SKIP_CYC = LINE_SKIP_CYCLES,
  parameter int unsigned FRAME_OVH_CYC = FRAME_OVH_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire pswo_shift_type shift_select,
  input wire logic wide_mode,
  input wire logic [COORD_W-1:0] win_first_col,
  input wire logic [COORD_W-1:0] win_col_count,
  input wire logic [COORD_W-1:0] win_first_line,
  input wire logic [COORD_W-1:0] win_line_count,
  output logic config_busy,
  output logic frame_period_short,
  input wire logic pixel_clock,
  input wire logic sensor_frame,
  input wire logic sensor_line,
  input wire logic [SAMPLE_W-1:0] sensor_sample,
  output logic [SAMPLE_W-1:0] pixel_data,
  output logic line_valid_flag,
  output logic frame_valid_flag
);
  // ****************************************
  // pixel shaping
  // ****************************************
  function automatic logic [SAMPLE_W-1:0] shape(input logic [SAMPLE_W-1:0] s,
      input pswo_shift_type sh, input logic wide);
    logic [SAMPLE_W-1:0] r;
    case (sh)
      SHIFT_ONCE: r = s[9] ? SAT_VALUE : {s[8:0], 1'b0};
      SHIFT_TWICE: r = (s[9] | s[8]) ? SAT_VALUE : {s[7:0], 2'b00};
      default: r = s;
    endcase
    // narrow mode keeps the top eight bits of the shifted word
    if (!wide) begin
      r = {2'b00, r[9:2]};
    end
    return r;
  endfunction : shape

  // ****************************************
  // settings capture, system clock
  // ****************************************
  pswo_shift_type hold_shift;
  logic hold_wide;
  logic [COORD_W-1:0] hold_first_col;
  logic [COORD_W-1:0] hold_col_count;
  logic [COORD_W-1:0] hold_first_line;
  logic [COORD_W-1:0] hold_line_count;
  logic req_toggle;
  logic ack_sync1;
  logic ack_sync2;
  logic ack_toggle;
  logic pending;
  logic differs;

  assign pending = req_toggle != ack_sync2;
  assign differs = shift_select != hold_shift || wide_mode != hold_wide
    || win_first_col != hold_first_col || win_col_count != hold_col_count
    || win_first_line != hold_first_line || win_line_count != hold_line_count;

  // hold stays frozen while a transfer is in flight, so the far side reads stable words
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hold_shift <= SHIFT_NONE;
      hold_wide <= 1'b0;
      hold_first_col <= WIN_FIRST_RST;
      hold_col_count <= WIN_COUNT_RST;
      hold_first_line <= WIN_FIRST_RST;
      hold_line_count <= WIN_COUNT_RST;
      req_toggle <= 1'b0;
    end else if (!pending && differs) begin
      hold_shift <= shift_select;
      hold_wide <= wide_mode;
      hold_first_col <= win_first_col;
      hold_col_count <= win_col_count;
      hold_first_line <= win_first_line;
      hold_line_count <= win_line_count;
      req_toggle <= ~req_toggle;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_sync1 <= 1'b0;
      ack_sync2 <= 1'b0;
      config_busy <= 1'b0;
    end else begin
      ack_sync1 <= ack_toggle;
      ack_sync2 <= ack_sync1;
      config_busy <= pending || differs;
    end
  end

  // ****************************************
  // link reset and settings receive
  // ****************************************
  logic link_rst_a;
  logic link_rst_n;
  logic req_sync1;
  logic req_sync2;
  logic frame_prev;
  logic frame_rise;
  logic frame_toggle;
  pswo_shift_type next_shift;
  logic next_wide;
  logic [COORD_W-1:0] next_first_col;
  logic [COORD_W-1:0] next_col_count;
  logic [COORD_W-1:0] next_first_line;
  logic [COORD_W-1:0] next_line_count;
  pswo_shift_type act_shift;
  logic act_wide;
  logic [COORD_W-1:0] act_first_col;
  logic [COORD_W-1:0] act_col_end;
  logic [COORD_W-1:0] act_first_line;
  logic [COORD_W-1:0] act_line_end;

  always_ff @(posedge pixel_clock or negedge arst_n) begin
    if (!arst_n) begin
      link_rst_a <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      link_rst_a <= 1'b1;
      link_rst_n <= link_rst_a;
    end
  end

  always_ff @(posedge pixel_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      req_sync1 <= 1'b0;
      req_sync2 <= 1'b0;
      ack_toggle <= 1'b0;
      next_shift <= SHIFT_NONE;
      next_wide <= 1'b0;
      next_first_col <= WIN_FIRST_RST;
      next_col_count <= WIN_COUNT_RST;
      next_first_line <= WIN_FIRST_RST;
      next_line_count <= WIN_COUNT_RST;
    end else begin
      req_sync1 <= req_toggle;
      req_sync2 <= req_sync1;
      if (req_sync2 != ack_toggle) begin
        next_shift <= hold_shift;
        next_wide <= hold_wide;
        next_first_col <= hold_first_col;
        next_col_count <= hold_col_count;
        next_first_line <= hold_first_line;
        next_line_count <= hold_line_count;
        ack_toggle <= req_sync2;
      end
    end
  end

  assign frame_rise = sensor_frame && !frame_prev;

  // settings taken only as a frame opens, never part way through one
  always_ff @(posedge pixel_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      frame_prev <= 1'b0;
      frame_toggle <= 1'b0;
      act_shift <= SHIFT_NONE;
      act_wide <= 1'b0;
      act_first_col <= WIN_FIRST_RST;
      act_col_end <= WIN_FIRST_RST + WIN_COUNT_RST;
      act_first_line <= WIN_FIRST_RST;
      act_line_end <= WIN_FIRST_RST + WIN_COUNT_RST;
    end else begin
      frame_prev <= sensor_frame;
      if (frame_rise) begin
        frame_toggle <= ~frame_toggle;
        act_shift <= next_shift;
        act_wide <= next_wide;
        act_first_col <= next_first_col;
        act_col_end <= next_first_col + next_col_count;
        act_first_line <= next_first_line;
        act_line_end <= next_first_line + next_line_count;
      end
    end
  end

  // ****************************************
  // position counters and output stage
  // ****************************************
  logic [COORD_W-1:0] col_cnt;
  logic [COORD_W-1:0] line_cnt;
  logic line_prev;
  logic [COORD_W-1:0] col_num;
  logic [COORD_W-1:0] line_num;
  logic in_line;
  logic in_win;

  assign col_num = col_cnt + 11'h001;
  assign line_num = line_cnt + 11'h001;
  assign in_line = line_num >= act_first_line && line_num < act_line_end;
  assign in_win = sensor_line && in_line && col_num >= act_first_col
    && col_num < act_col_end;

  always_ff @(posedge pixel_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      col_cnt <= 11'h000;
      line_cnt <= 11'h000;
      line_prev <= 1'b0;
    end else begin
      line_prev <= sensor_line;
      col_cnt <= sensor_line ? col_cnt + 11'h001 : 11'h000;
      if (!sensor_frame) begin
        line_cnt <= 11'h000;
      end else if (line_prev && !sensor_line) begin
        line_cnt <= line_cnt + 11'h001;
      end
    end
  end

  // skipped lines and columns outside the window leave as dark, invalid pixels
  always_ff @(posedge pixel_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pixel_data <= DARK_VALUE;
      line_valid_flag <= 1'b0;
      frame_valid_flag <= 1'b0;
    end else begin
      frame_valid_flag <= sensor_frame;
      line_valid_flag <= in_win;
      pixel_data <= in_win ? shape(sensor_sample, act_shift, act_wide) : DARK_VALUE;
    end
  end

  // ****************************************
  // frame period check, system clock
  // ****************************************
  logic fr_sync1;
  logic fr_sync2;
  logic fr_prev;
  logic fr_event;
  logic frame_seen;
  logic [PERIOD_W-1:0] period_cnt;
  logic [PERIOD_W-1:0] min_cycles;

  assign fr_event = fr_sync2 != fr_prev;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fr_sync1 <= 1'b0;
      fr_sync2 <= 1'b0;
      fr_prev <= 1'b0;
      frame_seen <= 1'b0;
      period_cnt <= PERIOD_ZERO;
      min_cycles <= PERIOD_ZERO;
      frame_period_short <= 1'b0;
    end else begin
      fr_sync1 <= frame_toggle;
      fr_sync2 <= fr_sync1;
      fr_prev <= fr_sync2;
      min_cycles <= PERIOD_W'(hold_line_count * LINE_WIN_CYC)
        + PERIOD_W'((ARRAY_LINES - hold_line_count) * LINE_SKIP_CYC)
        + PERIOD_W'(FRAME_OVH_CYC);
      if (fr_event) begin
        frame_seen <= 1'b1;
        frame_period_short <= frame_seen && period_cnt < min_cycles;
        period_cnt <= PERIOD_ZERO;
      end else if (period_cnt != {PERIOD_W{1'b1}}) begin
        period_cnt <= period_cnt + 26'h0000001;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [SAMPLE_W-1:0] chk_sample;
  pswo_shift_type chk_shift;
  logic chk_wide;
  logic chk_win;
  always_ff @(posedge pixel_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      chk_sample <= DARK_VALUE;
      chk_shift <= SHIFT_NONE;
      chk_wide <= 1'b0;
      chk_win <= 1'b0;
    end else begin
      chk_sample <= sensor_sample;
      chk_shift <= act_shift;
      chk_wide <= act_wide;
      chk_win <= in_win;
    end
  end
  sequence frame_open_s;
    !sensor_frame ##1 sensor_frame;
  endsequence
  sequence frame_valid_s;
    frame_valid_flag;
  endsequence
  narrow_none_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    chk_win && !chk_wide && chk_shift == SHIFT_NONE |-> pixel_data == {2'b00, chk_sample[9:2]})
    else $error("narrow no shift bits wrong");
  narrow_once_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    chk_win && !chk_wide && chk_shift == SHIFT_ONCE && !chk_sample[9]
    |-> pixel_data == {2'b00, chk_sample[8:1]})
    else $error("narrow single shift bits wrong");
  narrow_twice_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    chk_win && !chk_wide && chk_shift == SHIFT_TWICE && chk_sample[9:8] == 2'h0
    |-> pixel_data == {2'b00, chk_sample[7:0]})
    else $error("narrow double shift bits wrong");
  once_sat_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    chk_win && chk_shift == SHIFT_ONCE && chk_sample[9]
    |-> pixel_data == (chk_wide ? SAT_VALUE : 10'h0ff))
    else $error("single shift not saturated");
  twice_sat_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    chk_win && chk_shift == SHIFT_TWICE && (chk_sample[9] || chk_sample[8])
    |-> pixel_data == (chk_wide ? SAT_VALUE : 10'h0ff))
    else $error("double shift not saturated");
  wide_once_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    chk_win && chk_wide && chk_shift == SHIFT_ONCE && !chk_sample[9]
    |-> pixel_data == {chk_sample[8:0], 1'b0})
    else $error("wide single shift bits wrong");
  wide_twice_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    chk_win && chk_wide && chk_shift == SHIFT_TWICE && chk_sample[9:8] == 2'h0
    |-> pixel_data == {chk_sample[7:0], 2'b00})
    else $error("wide double shift bits wrong");
  line_gate_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    line_valid_flag == chk_win && (!line_valid_flag || ($past(sensor_line) && $past(in_line))))
    else $error("line valid outside window");
  col_edges_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    $rose(line_valid_flag) |-> $past(col_num) == $past(act_first_col))
    else $error("line valid rose off first column");
  col_fall_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    $fell(line_valid_flag) && $past(sensor_line) |-> $past(col_num) == $past(act_col_end))
    else $error("line valid fell off window end");
  dark_pixel_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    !line_valid_flag |-> pixel_data == DARK_VALUE)
    else $error("invalid pixel not dark");
  frame_on_time_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    frame_open_s |=> frame_valid_s)
    else $error("frame valid late");
  frame_hold_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    $past(sensor_frame) |-> frame_valid_flag)
    else $error("frame valid dropped early");
  frame_bound_a: assert property (@(posedge pixel_clock) disable iff (!link_rst_n)
    $changed(act_first_line) || $changed(act_shift) |-> $past(frame_rise))
    else $error("settings changed inside frame");
  period_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    fr_event && frame_seen |=> frame_period_short == ($past(period_cnt) < $past(min_cycles)))
    else $error("frame period flag wrong");
endmodule : pswo_core

//--- pswo_grabber.sv
// pswo_grabber: frame grabber model that tallies what each frame delivers
`timescale 1ns/10ps
module pswo_grabber import pswo_pkg::*; (
  input wire logic pixel_clock,
  input wire logic arst_n,
  input wire logic [SAMPLE_W-1:0] pixel_data,
  input wire logic line_valid_flag,
  input wire logic frame_valid_flag,
  output int valid_count,
  output int line_count,
  output int lead_count,
  output int frame_len,
  output int dark_bad,
  output logic [SAMPLE_W-1:0] first_data,
  output logic data_mixed
);
  // ****************************************
  // capture
  // ****************************************
  // tallies restart at each frame rise, so they stay readable after the frame ends
  logic fv_prev;
  logic lv_prev;
  logic lv_seen;

  always_ff @(posedge pixel_clock or negedge arst_n) begin
    if (!arst_n) begin
      fv_prev <= 1'b0;
      lv_prev <= 1'b0;
      lv_seen <= 1'b0;
      valid_count <= 0;
      line_count <= 0;
      lead_count <= 0;
      frame_len <= 0;
      dark_bad <= 0;
      first_data <= '0;
      data_mixed <= 1'b0;
    end else begin
      fv_prev <= frame_valid_flag;
      if (frame_valid_flag && !fv_prev) begin
        lv_prev <= 1'b0;
        lv_seen <= 1'b0;
        valid_count <= 0;
        line_count <= 0;
        lead_count <= 1;
        frame_len <= 1;
        dark_bad <= 0;
        data_mixed <= 1'b0;
      end else if (frame_valid_flag) begin
        frame_len <= frame_len + 1;
        lv_prev <= line_valid_flag;
        if (!lv_seen && !line_valid_flag) begin
          lead_count <= lead_count + 1;
        end
        if (line_valid_flag) begin
          lv_seen <= 1'b1;
          valid_count <= valid_count + 1;
          if (!lv_prev) begin
            line_count <= line_count + 1;
          end
          if (!lv_seen) begin
            first_data <= pixel_data;
          end else if (pixel_data !== first_data) begin
            data_mixed <= 1'b1;
          end
        end else if (pixel_data !== DARK_VALUE) begin
          dark_bad <= dark_bad + 1;
        end
      end
    end
  end
endmodule : pswo_grabber

//--- tb_top.sv
// tb_top: self-checking bench for the pixel shift and window output block
`timescale 1ns/10ps
module tb_top import pswo_pkg::*; ;
  logic clock = 1'b0;
  logic pixel_clock = 1'b0;
  logic arst_n = 1'b0;
  pswo_shift_type shift_select = SHIFT_NONE;
  logic wide_mode = 1'b0;
  logic [COORD_W-1:0] win_first_col = 11'h001;
  logic [COORD_W-1:0] win_col_count = 11'h3ec;
  logic [COORD_W-1:0] win_first_line = 11'h001;
  logic [COORD_W-1:0] win_line_count = 11'h3ec;
  logic config_busy;
  logic frame_period_short;
  logic sensor_frame = 1'b0;
  logic sensor_line = 1'b0;
  logic [SAMPLE_W-1:0] sensor_sample = 10'h000;
  logic [SAMPLE_W-1:0] pixel_data;
  logic line_valid_flag;
  logic frame_valid_flag;
  int valid_count, line_count, lead_count, frame_len, dark_bad, sf_len;
  logic [SAMPLE_W-1:0] first_data;
  logic data_mixed;
  int num_errors = 0;
  int n_compared = 0;
  logic [SAMPLE_W-1:0] samples [3] = '{10'h0b5, 10'h1a3, 10'h2c6};

  always #2.5 clock = ~clock;
  always #16 pixel_clock = ~pixel_clock;
  always @(posedge pixel_clock) if (sensor_frame === 1'b1) sf_len <= sf_len + 1;

  // shortened line and overhead counts keep the frame period check affordable
  pswo_core #(.LINE_WIN_CYC(4), .LINE_SKIP_CYC(2), .FRAME_OVH_CYC(16)) pswo_core_i (
    .clock(clock), .arst_n(arst_n), .shift_select(shift_select), .wide_mode(wide_mode),
    .win_first_col(win_first_col), .win_col_count(win_col_count),
    .win_first_line(win_first_line), .win_line_count(win_line_count),
    .config_busy(config_busy), .frame_period_short(frame_period_short),
    .pixel_clock(pixel_clock), .sensor_frame(sensor_frame), .sensor_line(sensor_line),
    .sensor_sample(sensor_sample), .pixel_data(pixel_data),
    .line_valid_flag(line_valid_flag), .frame_valid_flag(frame_valid_flag));

  pswo_grabber pswo_grabber_i (
    .pixel_clock(pixel_clock), .arst_n(arst_n), .pixel_data(pixel_data),
    .line_valid_flag(line_valid_flag), .frame_valid_flag(frame_valid_flag),
    .valid_count(valid_count), .line_count(line_count), .lead_count(lead_count),
    .frame_len(frame_len), .dark_bad(dark_bad), .first_data(first_data),
    .data_mixed(data_mixed));

  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // expected output value, worked out independently of the design
  function automatic logic [9:0] shape(input logic [9:0] s, input int m, input logic w);
    logic [9:0] r;
    if (w) begin
      r = (m == 0) ? s : (m == 1) ? {s[8:0], 1'b0} : {s[7:0], 2'b00};
    end else begin
      r = {2'b00, (m == 0) ? s[9:2] : (m == 1) ? s[8:1] : s[7:0]};
    end
    if ((m == 1 && s[9]) || (m == 2 && (s[9] || s[8]))) begin
      r = w ? 10'h3ff : 10'h0ff;
    end
    return r;
  endfunction : shape

  task automatic set_cfg(input int m, input logic w, input logic [10:0] fc, input logic [10:0] cc,
                         input logic [10:0] fl, input logic [10:0] lc);
    int i;
    @(posedge clock);
    #1;
    shift_select = pswo_shift_type'(m);
    wide_mode = w;
    win_first_col = fc;
    win_col_count = cc;
    win_first_line = fl;
    win_line_count = lc;
    repeat (3) @(posedge clock);
    #1;
    i = 0;
    while (config_busy !== 1'b0 && i < 400) begin
      @(posedge clock);
      #1;
      i++;
    end
    if (i >= 400) begin
      check("config_busy", 32'h0, {31'h0, config_busy});
      report_and_stop();
    end
    repeat (4) @(posedge pixel_clock);
  endtask : set_cfg

  // one frame of nl lines by np pixels, all of value v; mid changes the shift in flight
  task automatic run_frame(input int nl, input int np, input logic [9:0] v, input bit mid);
    @(posedge pixel_clock);
    #1;
    sf_len = 0;
    sensor_frame = 1'b1;
    for (int j = 0; j < nl; j++) begin
      for (int k = 0; k < np; k++) begin
        @(posedge pixel_clock);
        #1;
        sensor_line = 1'b1;
        sensor_sample = v;
      end
      @(posedge pixel_clock);
      #1;
      sensor_line = 1'b0;
      sensor_sample = ~v;
      if (mid && j == 0) begin
        shift_select = SHIFT_TWICE;
      end
    end
    repeat (3) @(posedge pixel_clock);
    #1;
    sensor_frame = 1'b0;
    repeat (3) @(posedge pixel_clock);
  endtask : run_frame

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    // reset spans three link clock edges, which the link-side synchroniser needs
    repeat (3) @(posedge pixel_clock);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge pixel_clock);
    for (int w = 0; w < 2; w++) begin
      for (int m = 0; m < 3; m++) begin
        for (int s = 0; s < 3; s++) begin
          set_cfg(m, w[0], 11'h001, 11'h3ec, 11'h001, 11'h3ec);
          run_frame(2, 8, samples[s], 1'b0);
          check("pixel_data", {22'h0, shape(samples[s], m, w[0])}, {22'h0, first_data});
          check("valid_count", 32'd16, valid_count);
          check("data_mixed", 32'h0, {31'h0, data_mixed});
        end
      end
    end
    check("frame_period_short", 32'h1, {31'h0, frame_period_short});
    set_cfg(0, 1'b0, 11'h003, 11'h004, 11'h003, 11'h002);
    run_frame(6, 10, 10'h0b5, 1'b1);
    check("valid_count", 32'd8, valid_count);
    check("line_count", 32'd2, line_count);
    check("lead_count", 32'd25, lead_count);
    check("dark_bad", 32'd0, dark_bad);
    check("frame_len", sf_len, frame_len);
    check("pixel_data", 32'h2d, {22'h0, first_data});
    check("data_mixed", 32'h0, {31'h0, data_mixed});
    repeat (20) @(posedge pixel_clock);
    run_frame(6, 10, 10'h0b5, 1'b0);
    check("pixel_data", 32'hb5, {22'h0, first_data});
    set_cfg(0, 1'b0, 11'h001, 11'h3ec, 11'h001, 11'h3ec);
    // a gap longer than the minimum frame period clears the short-period flag
    repeat (800) @(posedge pixel_clock);
    run_frame(2, 8, 10'h0b5, 1'b0);
    check("frame_period_short", 32'h0, {31'h0, frame_period_short});
    check("lead_count", 32'd1, lead_count);
    report_and_stop();
  end
endmodule : tb_top
